// ===== design/charger_mode_status_logic.sv
// Purpose: Mode decode, input limit selection, charge sequencing and status pins
// Assumes: Comparator flags and pins are asynchronous and pass a 3-stage filter
// Notes:   Open-drain pins drive low when their enable_n is low
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Behaviour
// - Source-select high means USB host supply, low means wall adapter.
// - Power-good pulled low only with input in range, above sleep, limit over 30mA.
// - Charge-status low while charging, released high when done or disabled.
// - Any fault makes charge-status blink at 1Hz.
// - Status change or fault gives one 256us low pulse on interrupt output.
// - Buck mode on USB: limit 500mA with limit/boost pin high, else 100mA.
// - Boost only when mode field is 10 and limit/boost pin is high.
// - Charging only when mode field is 01 and inhibit pin is low.
// - Effective limit is the smaller of resistor cap and the selected USB or code limit.
// - Resistor-programmed limit is clamped to at least 500mA.
// - Charge advances trickle, preconditioning, constant current, constant voltage.
// - Charging ends when full and restarts below recharge threshold.
// - Watchdog expiry without host service stops charging.
// - Short-tripped battery gets float voltage before any charge phase.
// - First thermistor out of window suspends charging until back inside.
// - Second thermistor out of window also suspends charging.
module charger_mode_status_logic
  import charger_pkg::*;
#(
  parameter int unsigned INT_CYC   = INT_PULSE_CYC,
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  parameter longint unsigned WDOG_LIMIT = WDOG_CYC
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Mode pins
  input  wire logic        source_select,
  input  wire logic        host_limit_boost_pin,
  input  wire logic        charge_inhibit_pin,
  // Input supply comparators
  input  wire logic        input_above_undervoltage_lockout,
  input  wire logic        input_overvoltage,
  input  wire logic        input_above_sleep,
  input  wire logic [11:0] resistor_current_cap,
  // Battery comparators
  input  wire logic        batt_short_tripped,
  input  wire logic        batt_above_short,
  input  wire logic        batt_above_lowv,
  input  wire logic        batt_at_regulation,
  input  wire logic        batt_term_current,
  input  wire logic        batt_below_recharge,
  // Thermistor window comparators
  input  wire logic        thermistor_a_ok,
  input  wire logic        thermistor_b_ok,
  // Open-drain outputs with readback
  input  wire logic        input_good_n_i,
  output logic             input_good_n_o,
  output logic             input_good_n_oe_n,
  input  wire logic        charge_status_i,
  output logic             charge_status_o,
  output logic             charge_status_oe_n,
  input  wire logic        host_irq_n_i,
  output logic             host_irq_n_o,
  output logic             host_irq_n_oe_n,
  // Power stage controls
  output logic             charge_enable,
  output logic             float_reactivate,
  output logic             boost_enable,
  output logic [2:0]       charge_phase,
  output logic [11:0]      effective_limit_ma
);

  localparam int unsigned NSYNC = 29;
  // Smaller of two currents
  function automatic logic [11:0] min_ma(input logic [11:0] a, input logic [11:0] b);
    min_ma = (a < b) ? a : b;
  endfunction

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  // Gather every pin and comparator from outside the clock domain
  assign raw = {resistor_current_cap, host_irq_n_i, charge_status_i, input_good_n_i,
                thermistor_b_ok, thermistor_a_ok, batt_below_recharge, batt_term_current,
                batt_at_regulation, batt_above_lowv, batt_above_short, batt_short_tripped,
                input_above_sleep, input_overvoltage, input_above_undervoltage_lockout,
                charge_inhibit_pin, host_limit_boost_pin, source_select};

  // Three-stage filter; a bit changes only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_comb
      begin
        flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      flt_q <= '0;
    end
    else
    begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  logic        src_usb, lb_pin, inhibit, undervoltage_lockout_ok, ov, sleep_ok;
  logic        b_short, b_abv_short, b_abv_lowv, b_at_reg, b_term, b_rechg;
  logic        therm_a, therm_b, pg_rb, stat_rb, irq_rb;
  logic [11:0] cap_ma;
  // Filtered input split; the split mirrors the gather order above, MSB first
  assign {cap_ma, irq_rb, stat_rb, pg_rb, therm_b, therm_a, b_rechg, b_term, b_at_reg,
          b_abv_lowv, b_abv_short, b_short, sleep_ok, ov, undervoltage_lockout_ok, inhibit, lb_pin,
          src_usb} = flt_q;
  // Register state
  logic [2:0]  code_q, code_d;
  logic [1:0]  mode_q, mode_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [31:0] wdog_q, wdog_d;
  logic [11:0] lim_q, lim_d;
  phase_t      ph_q, ph_d;
  logic [31:0] blink_q, blink_d;
  logic [31:0] irq_cnt_q, irq_cnt_d;
  logic [7:0]  evt_q, evt_d;
  logic        wexp_q, wexp_d, pg_n_q, pg_n_d, boost_q, boost_d, chg_q, chg_d;
  logic        react_q, react_d, stat_oe_q, stat_oe_d, blink_ph_q, blink_ph_d;
  logic        irq_oe_q, irq_oe_d, low_q;
  logic        therm_fault, fault, chg_allowed, event_now;
  logic [11:0] sel_ma, clamp_ma;
  logic [7:0]  status_v;

  // Register writes, watchdog, and read data one cycle after the strobe
  always_comb
  begin
    code_d  = code_q;
    mode_d  = mode_q;
    rdata_d = 8'h00;
    wdog_d  = wdog_q;
    wexp_d  = wexp_q;
    if (reg_wr && reg_addr == ADDR_INPUT_CTRL)
      code_d = reg_wdata[LIMIT_CODE_LSB +: 3];
    if (reg_wr && reg_addr == ADDR_MODE_CTRL)
      mode_d = reg_wdata[MODE_FIELD_LSB +: 2];
    // Host writes service the watchdog; expiry wins a same-cycle write
    if (reg_wr)
    begin
      wdog_d = 32'h0000_0000;
      wexp_d = 1'b0;
    end
    else if (!wexp_q)
      wdog_d = wdog_q + 32'h0000_0001;
    if (!wexp_q && 64'(wdog_q) >= WDOG_LIMIT - 64'd1)
      wexp_d = 1'b1;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_INPUT_CTRL: rdata_d = {5'h00, code_q};
        ADDR_MODE_CTRL:  rdata_d = {2'h0, mode_q, 4'h0};
        ADDR_STATUS:     rdata_d = status_v;
        ADDR_PIN_STATUS: rdata_d = {2'h0, irq_rb, stat_rb, pg_rb, inhibit, lb_pin, src_usb};
        ADDR_LIMIT_LO:   rdata_d = lim_q[7:0];
        ADDR_LIMIT_HI:   rdata_d = {4'h0, lim_q[11:8]};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  assign status_v = {therm_fault, wexp_q, boost_q, ~pg_n_q, chg_q, ph_q};
  // Input limit and power-good evaluation
  always_comb
  begin
    // Resistor cap never below its floor
    clamp_ma = (cap_ma < CAP_FLOOR_MA) ? CAP_FLOOR_MA : cap_ma;
    // USB host in buck mode follows the limit/boost pin
    if (src_usb && mode_q != MODE_BOOST)
      sel_ma = lb_pin ? USB_HIGH_MA : USB_LOW_MA;
    else
      sel_ma = CODE_MA[code_q];
    // Lower of resistor and selected limit
    lim_d = min_ma(clamp_ma, sel_ma);
    // Good input needs range, sleep margin and usable limit
    pg_n_d = !(undervoltage_lockout_ok && !ov && sleep_ok && lim_q > GOOD_LIMIT_MA);
    // Boost needs mode 10 and pin high
    boost_d = (mode_q == MODE_BOOST) && lb_pin;
  end

  // Either thermistor outside its window is a fault
  assign therm_fault = !therm_a || !therm_b;
  assign fault       = therm_fault || wexp_q || ov;
  // Charge permission from mode field, inhibit pin and watchdog
  assign chg_allowed = (mode_q == MODE_CHARGE) && !inhibit && !wexp_q;

  // Charge phase sequencing
  always_comb
  begin
    ph_d    = ph_q;
    chg_d   = 1'b0;
    react_d = 1'b0;
    if (!chg_allowed)
      ph_d = PH_IDLE;
    // Thermal fault holds the phase but stops current
    else if (!therm_fault)
    begin
      unique case (ph_q)
        PH_IDLE:    ph_d = b_short ? PH_REACT : PH_TRICKLE;
        PH_REACT:   ph_d = b_short ? PH_REACT : PH_TRICKLE;
        // Voltage thresholds advance the phases in order
        PH_TRICKLE: ph_d = b_abv_short ? PH_PRECOND : PH_TRICKLE;
        PH_PRECOND: ph_d = b_abv_lowv ? PH_CC : PH_PRECOND;
        PH_CC:      ph_d = b_at_reg ? PH_CV : PH_CC;
        // Terminate when full, restart on recharge threshold
        PH_CV:      ph_d = b_term ? PH_DONE : PH_CV;
        PH_DONE:    ph_d = b_rechg ? PH_TRICKLE : PH_DONE;
        default:    ph_d = PH_IDLE;
      endcase
      react_d = (ph_d == PH_REACT);
      chg_d   = (ph_d != PH_IDLE) && (ph_d != PH_DONE) && (ph_d != PH_REACT);
    end
  end

  // Charge-status pin with fault blink
  always_comb
  begin
    blink_d    = blink_q + 32'h0000_0001;
    blink_ph_d = blink_ph_q;
    // Equal half periods from the clock divider
    if (blink_q >= BLINK_CYC - 1)
    begin
      blink_d    = 32'h0000_0000;
      blink_ph_d = ~blink_ph_q;
    end
    if (fault)
      stat_oe_d = blink_ph_q;
    else
      stat_oe_d = !chg_q;
  end

  // Interrupt pulse on any status change or new fault
  always_comb
  begin
    evt_d     = {fault, status_v[6:0]};
    event_now = (evt_d != evt_q);
    irq_cnt_d = irq_cnt_q;
    irq_oe_d  = irq_oe_q;
    // A new event restarts the low pulse
    if (event_now)
    begin
      irq_cnt_d = 32'h0000_0000;
      irq_oe_d  = 1'b0;
    end
    else if (!irq_oe_q)
    begin
      if (irq_cnt_q >= INT_CYC - 1)
        irq_oe_d = 1'b1;
      else
        irq_cnt_d = irq_cnt_q + 32'h0000_0001;
    end
  end

  // Register every state group
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      code_q     <= LIMIT_CODE_RST;
      mode_q     <= MODE_FIELD_RST;
      rdata_q    <= 8'h00;
      wdog_q     <= 32'h0000_0000;
      wexp_q     <= 1'b0;
      pg_n_q     <= 1'b1;
      boost_q    <= 1'b0;
      lim_q      <= 12'h000;
      ph_q       <= PH_IDLE;
      chg_q      <= 1'b0;
      react_q    <= 1'b0;
      stat_oe_q  <= 1'b1;
      blink_q    <= 32'h0000_0000;
      blink_ph_q <= 1'b0;
      irq_cnt_q  <= 32'h0000_0000;
      irq_oe_q   <= 1'b1;
      evt_q      <= 8'h00;
      low_q      <= 1'b0;
    end
    else
    begin
      code_q     <= code_d;
      mode_q     <= mode_d;
      rdata_q    <= rdata_d;
      wdog_q     <= wdog_d;
      wexp_q     <= wexp_d;
      pg_n_q     <= pg_n_d;
      boost_q    <= boost_d;
      lim_q      <= lim_d;
      ph_q       <= ph_d;
      chg_q      <= chg_d;
      react_q    <= react_d;
      stat_oe_q  <= stat_oe_d;
      blink_q    <= blink_d;
      blink_ph_q <= blink_ph_d;
      irq_cnt_q  <= irq_cnt_d;
      irq_oe_q   <= irq_oe_d;
      evt_q      <= evt_d;
      low_q      <= 1'b0;
    end
  end

  // Outputs straight from flops; open-drain data is always low
  assign reg_rdata          = rdata_q;
  assign input_good_n_o     = low_q;
  assign input_good_n_oe_n  = pg_n_q;
  assign charge_status_o    = low_q;
  assign charge_status_oe_n = stat_oe_q;
  assign host_irq_n_o       = low_q;
  assign host_irq_n_oe_n    = irq_oe_q;
  assign charge_enable      = chg_q;
  assign float_reactivate   = react_q;
  assign boost_enable       = boost_q;
  assign charge_phase       = ph_q;
  assign effective_limit_ma = lim_q;
endmodule

// ===== design/charger_pkg.sv
// Purpose: Shared constants and types of the charger mode and status logic
// Assumes: 100 MHz system clock, 8-bit register port with 4-bit address
// Notes:   Current figures are held in mA in 12-bit fields
package charger_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned INT_PULSE_US    = 256;
  localparam int unsigned INT_PULSE_CYC   = INT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLINK_HZ        = 1;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned WDOG_TIME_S     = 40;
  localparam longint unsigned WDOG_CYC    = longint'(WDOG_TIME_S) * CLK_HZ;

  // Register offsets
  localparam logic [3:0] ADDR_INPUT_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_MODE_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam logic [3:0] ADDR_PIN_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_LIMIT_LO    = 4'h4;
  localparam logic [3:0] ADDR_LIMIT_HI    = 4'h5;

  // Field positions and reset values
  localparam int unsigned LIMIT_CODE_LSB  = 0;
  localparam int unsigned MODE_FIELD_LSB  = 4;
  localparam logic [2:0]  LIMIT_CODE_RST  = 3'h2;
  localparam logic [1:0]  MODE_FIELD_RST  = 2'h1;

  // Operating mode field encodings
  localparam logic [1:0] MODE_IDLE        = 2'h0;
  localparam logic [1:0] MODE_CHARGE      = 2'h1;
  localparam logic [1:0] MODE_BOOST       = 2'h2;

  // Current figures in mA
  localparam logic [11:0] USB_HIGH_MA     = 12'h01f4;
  localparam logic [11:0] USB_LOW_MA      = 12'h0064;
  localparam logic [11:0] CAP_FLOOR_MA    = 12'h01f4;
  localparam logic [11:0] GOOD_LIMIT_MA   = 12'h001e;
  localparam logic [11:0] CODE_MA [8]     = '{12'h0064, 12'h0096, 12'h01f4, 12'h0384,
                                              12'h04b0, 12'h05dc, 12'h07d0, 12'h0bb8};

  // Charge sequence states
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_REACT   = 3'b001,
    PH_TRICKLE = 3'b010,
    PH_PRECOND = 3'b011,
    PH_CC      = 3'b100,
    PH_CV      = 3'b101,
    PH_DONE    = 3'b110
  } phase_t;

endpackage

// ===== tb/charger_mode_status_logic_assertions.sv
// Purpose: Port checks for the charger mode and status logic
// Assumes: Bench runs short blink and pulse counts
// Notes:   Filtered inputs settle within about six edges
`timescale 1ns/10ps
module charger_checker
  import charger_pkg::*;
#(
  parameter int unsigned BLINK_CYC = 16
)(
  // Clock, reset and watched inputs
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        charge_inhibit_pin,
  input wire logic        input_above_undervoltage_lockout,
  input wire logic        input_overvoltage,
  input wire logic [11:0] resistor_current_cap,
  input wire logic        thermistor_a_ok,
  // Watched outputs
  input wire logic        input_good_n_o,
  input wire logic        input_good_n_oe_n,
  input wire logic        charge_status_o,
  input wire logic        charge_status_oe_n,
  input wire logic        host_irq_n_o,
  input wire logic        host_irq_n_oe_n,
  input wire logic        charge_enable,
  input wire logic        float_reactivate,
  input wire logic        boost_enable,
  input wire logic [2:0]  charge_phase,
  input wire logic [11:0] effective_limit_ma
);
  logic [7:0] fault_q;
  logic [7:0] hold_q;
  logic       oe_q;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Thermistor A fault age and time since the status pin last moved; saturate so they never wrap
  always_ff @(posedge mclk)
  begin
    oe_q    <= charge_status_oe_n;
    fault_q <= (!rstn || thermistor_a_ok) ? 8'h00 : fault_q + {7'h00, fault_q != 8'hff};
    hold_q  <= (!rstn || oe_q != charge_status_oe_n) ? 8'h00 : hold_q + {7'h00, hold_q != 8'hff};
  end
  property p_excl;
    !(boost_enable && charge_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("boost and charging both on");
  property p_inhibit;
    charge_inhibit_pin [*8] |=> !charge_enable;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("charging while inhibited");
  property p_limit;
    $stable(resistor_current_cap) [*8] |-> effective_limit_ma <=
      ((resistor_current_cap > CAP_FLOOR_MA) ? resistor_current_cap : CAP_FLOOR_MA);
  endproperty
  a_limit: assert property (p_limit) else $error("limit above clamped cap");
  property p_good;
    (!input_above_undervoltage_lockout) [*8] |=> input_good_n_oe_n;
  endproperty
  a_good: assert property (p_good) else $error("power good below lockout");
  property p_irq;
    $fell(host_irq_n_oe_n) |-> (!host_irq_n_oe_n) [*8];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pulse too short");
  property p_od;
    !input_good_n_o && !charge_status_o && !host_irq_n_o;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  property p_status;
    (charge_enable && !input_overvoltage) [*8] |-> !charge_status_oe_n;
  endproperty
  a_status: assert property (p_status) else $error("status not low while charging");
  property p_blink;
    fault_q > 8'd40 |-> hold_q <= BLINK_CYC;
  endproperty
  a_blink: assert property (p_blink) else $error("status not blinking on fault");
  property p_react;
    float_reactivate |-> charge_phase == PH_REACT && !charge_enable;
  endproperty
  a_react: assert property (p_react) else $error("float outside reactivation");
  property p_phase;
    $changed(charge_phase) |-> charge_phase == $past(charge_phase) + 3'h1 ||
      charge_phase == PH_IDLE || $past(charge_phase) inside {PH_IDLE, PH_DONE};
  endproperty
  a_phase: assert property (p_phase) else $error("charge phase out of order");
  property p_phase_en;
    charge_enable |-> charge_phase inside {PH_TRICKLE, PH_PRECOND, PH_CC, PH_CV};
  endproperty
  a_phase_en: assert property (p_phase_en) else $error("charging outside phases");
  c_irq: cover property ($fell(host_irq_n_oe_n));
  c_react: cover property (float_reactivate);
  c_cv: cover property (charge_phase == PH_CV);
  c_boost: cover property (boost_enable);
endmodule
bind charger_mode_status_logic charger_checker #(.BLINK_CYC(BLINK_CYC)) u_charger_checker (
  .mclk(mclk), .rstn(rstn), .charge_inhibit_pin(charge_inhibit_pin),
  .input_above_undervoltage_lockout(input_above_undervoltage_lockout), .input_overvoltage(input_overvoltage),
  .resistor_current_cap(resistor_current_cap), .thermistor_a_ok(thermistor_a_ok),
  .input_good_n_o(input_good_n_o), .input_good_n_oe_n(input_good_n_oe_n),
  .charge_status_o(charge_status_o), .charge_status_oe_n(charge_status_oe_n),
  .host_irq_n_o(host_irq_n_o), .host_irq_n_oe_n(host_irq_n_oe_n),
  .charge_enable(charge_enable), .float_reactivate(float_reactivate),
  .boost_enable(boost_enable), .charge_phase(charge_phase),
  .effective_limit_ma(effective_limit_ma));

// ===== tb/charger_mode_status_logic_tb.sv
// Purpose: Self-checking bench for the charger mode and status logic
// Assumes: Short counts so blink, pulse and watchdog fit a short run
// Notes:   Outputs are compared once filters and registers have settled
`timescale 1ns/10ps
module charger_mode_status_logic_tb;
  import charger_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd_v, irq_pulses, pulses_v;
  logic        source_select = 1'b0, host_limit_boost_pin = 1'b0, charge_inhibit_pin = 1'b0;
  logic        input_above_undervoltage_lockout = 1'b1, input_overvoltage = 1'b0, input_above_sleep = 1'b1;
  logic [11:0] resistor_current_cap = 12'h0fff, cap_v, effective_limit_ma;
  logic        batt_short_tripped = 1'b0, batt_above_short = 1'b0, batt_above_lowv = 1'b0;
  logic        batt_at_regulation = 1'b0, batt_term_current = 1'b0, batt_below_recharge = 1'b0;
  logic        thermistor_a_ok = 1'b1, thermistor_b_ok = 1'b1, src_v, pin_v;
  logic        good_o, good_oe_n, stat_o, stat_oe_n, irq_o, irq_oe_n, good_line, stat_line;
  logic        irq_line, charge_enable, float_reactivate, boost_enable;
  logic [2:0]  charge_phase, code_v;
  logic [1:0]  mode_q = MODE_CHARGE;
  int          seed = 11, failures = 0, checks_done = 0;
  charger_mode_status_logic #(.INT_CYC(8), .BLINK_CYC(16), .WDOG_LIMIT(200))
  u_charger_mode_status_logic (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_select(source_select),
    .host_limit_boost_pin(host_limit_boost_pin), .charge_inhibit_pin(charge_inhibit_pin),
    .input_above_undervoltage_lockout(input_above_undervoltage_lockout), .input_overvoltage(input_overvoltage),
    .input_above_sleep(input_above_sleep), .resistor_current_cap(resistor_current_cap),
    .batt_short_tripped(batt_short_tripped), .batt_above_short(batt_above_short),
    .batt_above_lowv(batt_above_lowv), .batt_at_regulation(batt_at_regulation),
    .batt_term_current(batt_term_current), .batt_below_recharge(batt_below_recharge),
    .thermistor_a_ok(thermistor_a_ok), .thermistor_b_ok(thermistor_b_ok),
    .input_good_n_i(good_line), .input_good_n_o(good_o), .input_good_n_oe_n(good_oe_n),
    .charge_status_i(stat_line), .charge_status_o(stat_o), .charge_status_oe_n(stat_oe_n),
    .host_irq_n_i(irq_line), .host_irq_n_o(irq_o), .host_irq_n_oe_n(irq_oe_n),
    .charge_enable(charge_enable), .float_reactivate(float_reactivate),
    .boost_enable(boost_enable), .charge_phase(charge_phase),
    .effective_limit_ma(effective_limit_ma));
  status_pin_host_model u_status_pin_host_model (
    .good_o(good_o), .good_oe_n(good_oe_n), .stat_o(stat_o), .stat_oe_n(stat_oe_n),
    .irq_o(irq_o), .irq_oe_n(irq_oe_n), .good_line(good_line), .stat_line(stat_line),
    .irq_line(irq_line), .irq_pulses(irq_pulses));
  // Free-running clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    // Read data stand only in the cycle after the strobe; take them at its closing edge
    @(posedge mclk);
    rd_v = reg_rdata;
  endtask
  // Every settle writes the mode, which also keeps the watchdog fed
  task automatic settle();
    wr(ADDR_MODE_CTRL, {2'b00, mode_q, 4'h0});
    // End on an edge so the next pin change lands on a rising edge
    repeat (10) @(posedge mclk);
  endtask
  function automatic logic [11:0] exp_limit(input logic usb, input logic pin,
                                            input logic [1:0] m, input logic [2:0] code,
                                            input logic [11:0] cap);
    logic [11:0] sel;
    logic [11:0] flo;
    sel = (usb && m != MODE_BOOST) ? (pin ? USB_HIGH_MA : USB_LOW_MA) : CODE_MA[code];
    flo = (cap > CAP_FLOOR_MA) ? cap : CAP_FLOOR_MA;
    return (sel < flo) ? sel : flo;
  endfunction
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rd(ADDR_INPUT_CTRL);
    chk(rd_v, LIMIT_CODE_RST);
    rd(ADDR_MODE_CTRL);
    chk(rd_v, {2'b00, MODE_FIELD_RST, 4'h0});
    rd(4'hf);
    chk(rd_v, 12'h000);
    // Random source, pin, code and cap with low cap corners first
    for (int i = 0; i < 24; i++)
    begin
      src_v = 1'($random(seed));
      pin_v = 1'($random(seed));
      code_v = 3'($random(seed));
      cap_v = (i == 0) ? 12'h0000 : (i == 1) ? 12'h01f3 : 12'($random(seed));
      mode_q = (i % 3 == 2) ? MODE_BOOST : MODE_CHARGE;
      source_select <= src_v;
      host_limit_boost_pin <= pin_v;
      resistor_current_cap <= cap_v;
      wr(ADDR_INPUT_CTRL, {5'h00, code_v});
      settle();
      chk(effective_limit_ma, exp_limit(src_v, pin_v, mode_q, code_v, cap_v));
      chk(boost_enable, mode_q == MODE_BOOST && pin_v);
      chk(good_line, 1'b0);
      rd(ADDR_PIN_STATUS);
      chk(rd_v[1:0], {pin_v, src_v});
    end
    // Trip the short while idle, so its filter has settled before charging is allowed
    host_limit_boost_pin <= 1'b0;
    batt_short_tripped <= 1'b1;
    mode_q = MODE_IDLE;
    settle();
    chk(charge_phase, PH_IDLE);
    // Short-tripped battery then the full charge cycle
    mode_q = MODE_CHARGE;
    settle();
    chk({float_reactivate, charge_enable, charge_phase}, {2'b10, PH_REACT});
    batt_short_tripped <= 1'b0;
    settle();
    chk({charge_phase, stat_line}, {PH_TRICKLE, 1'b0});
    batt_above_short <= 1'b1;
    settle();
    chk(charge_phase, PH_PRECOND);
    batt_above_lowv <= 1'b1;
    settle();
    chk(charge_phase, PH_CC);
    batt_at_regulation <= 1'b1;
    settle();
    chk(charge_phase, PH_CV);
    batt_term_current <= 1'b1;
    settle();
    chk({charge_phase, charge_enable, stat_line}, {PH_DONE, 2'b01});
    batt_term_current <= 1'b0;
    batt_below_recharge <= 1'b1;
    settle();
    chk(charge_enable, 1'b1);
    charge_inhibit_pin <= 1'b1;
    settle();
    chk({charge_enable, charge_phase}, {1'b0, PH_IDLE});
    charge_inhibit_pin <= 1'b0;
    settle();
    // Each thermistor out of window in turn, held long enough to blink
    pulses_v = irq_pulses;
    for (int i = 0; i < 2; i++)
    begin
      thermistor_a_ok <= (i != 0);
      thermistor_b_ok <= (i != 1);
      settle();
      repeat (50) @(posedge mclk);
      rd(ADDR_STATUS);
      chk({charge_enable, rd_v[7]}, 2'b01);
      thermistor_a_ok <= 1'b1;
      thermistor_b_ok <= 1'b1;
      settle();
      chk(charge_enable, 1'b1);
    end
    chk(irq_pulses != pulses_v, 1'b1);
    // Starve the watchdog, then feed it again
    repeat (260) @(posedge mclk);
    rd(ADDR_STATUS);
    chk({charge_enable, rd_v[6]}, 2'b01);
    settle();
    chk(charge_enable, 1'b1);
    input_above_undervoltage_lockout <= 1'b0;
    settle();
    chk(good_line, 1'b1);
    input_above_undervoltage_lockout <= 1'b1;
    input_overvoltage <= 1'b1;
    settle();
    chk(good_line, 1'b1);
    input_overvoltage <= 1'b0;
    settle();
    chk(good_line, 1'b0);
    complete_run();
  end
endmodule

// ===== tb/status_pin_host_model.sv
// Purpose: Host side of the open-drain status pins
// Assumes: Every pin has a pull-up to the logic rail
// Notes:   Counts interrupt pulses the host would see
`timescale 1ns/10ps
module status_pin_host_model (
  // Device pin drives
  input wire logic       good_o,
  input wire logic       good_oe_n,
  input wire logic       stat_o,
  input wire logic       stat_oe_n,
  input wire logic       irq_o,
  input wire logic       irq_oe_n,
  // Line levels and pulse count
  output logic           good_line,
  output logic           stat_line,
  output logic           irq_line,
  output logic [7:0]     irq_pulses
);
  assign good_line = good_oe_n ? 1'b1 : good_o;
  assign stat_line = stat_oe_n ? 1'b1 : stat_o;
  assign irq_line  = irq_oe_n ? 1'b1 : irq_o;
  // Host counts falling edges, as an edge-triggered interrupt input would
  initial irq_pulses = 8'h00;
  always @(negedge irq_line) irq_pulses <= irq_pulses + 8'h01;
endmodule
